/* File: line_cycle_energy_accum.sv */
// line-cycle energy accumulation with calibration register file
//
// Contract
// - each line-mode energy register holds energy summed over whole half cycles
// - mode bits 0..2 enable line accumulation for watt, reactive, apparent
// - mode bits 3..5 choose which phases' crossings count half cycles
// - mode bit 7 makes the line measurement show period, not frequency
// - measurement mode bits 1:0 pick the measured phase, 00 phase A
// - 16-bit half-cycle count sets accumulation length
// - interrupt enable bit 12 gates the accumulation-done interrupt
// - reading the clearing status copy returns flags then clears them
// - crossings of all selected phases share one half-cycle count
// - period reading counts in 9.6 us units, 12 bits
// - gain trims scale energy by one plus signed value over 4096
// - watt energies at 0x01..03, reactive 0x04..06, apparent 0x07..09
// - phase trim delays 1.2 us per step one way, 2.4 us other
// - nine gain trims occupy 0x2a through 0x32
// - pulse-rate numerator and denominator pairs sit at 0x45..0x48
// - phase delay trims sit at 0x3f..0x41
module line_cycle_energy_accum import lca_pkg::*; #(
	parameter int ENERGY_W = 16,
	parameter int INC_W = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register port from the serial framer
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [DATA_W-1:0] regRdData,
	output logic regRdValid,
	// energy increments from the signal path, phase A in the low slice
	input wire logic energyValid,
	input wire logic [3*INC_W-1:0] wattInc,
	input wire logic [3*INC_W-1:0] reactiveInc,
	input wire logic [3*INC_W-1:0] apparentInc,
	input wire logic [2:0] zeroCross,
	// events
	output logic irqN,
	output logic accumDoneEvent,
	// calibration values to the signal path
	output logic [38:0] phaseDelayCycles,
	output logic [11:0] activePulseRateNum,
	output logic [11:0] activePulseRateDen,
	output logic [11:0] reactivePulseRateNum,
	output logic [11:0] reactivePulseRateDen
);

	logic [7:0] measModeCfg_r;
	logic [7:0] lineCycleModeCfg_r;
	logic [23:0] intEnable_r;
	logic [23:0] irqFlags_r;
	logic [23:0] irqFlags_nxt;
	logic [15:0] halfCycleCount_r;
	logic [16:0] halfCnt_r;
	logic [16:0] halfCnt_nxt;
	logic [11:0] gainTrim_r [9];
	logic [6:0] phaseTrim_r [3];
	logic signed [ENERGY_W-1:0] acc_r [9];
	logic signed [ENERGY_W-1:0] pub_r [9];
	logic signed [INC_W-1:0] rawInc [9];
	logic signed [INC_W-1:0] scaledInc [9];
	logic [11:0] linePeriodMeas;
	logic [2:0] lineEnable;
	logic [2:0] crossEnable;
	logic anyLine;
	logic periodEnd;
	logic flagsReadClear;
	logic energyReadClear;
	logic [DATA_W-1:0] rdMux;

	function automatic logic [1:0] countOnes(input logic [2:0] v);
		countOnes = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction : countOnes

	function automatic logic inRange(input logic [6:0] a,
			input logic [6:0] lo, input logic [6:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction : inRange

	// signed trim to delay in clock cycles
	function automatic logic [12:0] trimToCycles(input logic [6:0] t);
		logic [6:0] mag;
		mag = t[6] ? 7'(-t) : t;
		trimToCycles = t[6] ? 13'(mag * 13'(TRIM_NEG_CYC)) :
			13'(mag * 13'(TRIM_POS_CYC));
	endfunction : trimToCycles

	assign lineEnable = lineCycleModeCfg_r[LCM_ACCUM_LSB +: 3];
	assign crossEnable = lineCycleModeCfg_r[LCM_CROSS_LSB +: 3];
	assign anyLine = |lineEnable;

	// gain scaling of every increment
	for (genvar i = 0; i < 9; i++) begin : g_scale
		always_comb begin
			if (i < 3) begin
				rawInc[i] = wattInc[(i % 3) * INC_W +: INC_W];
			end else if (i < 6) begin
				rawInc[i] = reactiveInc[(i % 3) * INC_W +: INC_W];
			end else begin
				rawInc[i] = apparentInc[(i % 3) * INC_W +: INC_W];
			end
		end
		energy_gain_scale #(
			.INC_W(INC_W)
		) u_scale (
			.incIn(rawInc[i]),
			.gainTrim(gainTrim_r[i]),
			.incOut(scaledInc[i])
		);
	end

	line_period_meter u_period (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.zeroCross(zeroCross),
		.periodMeasureSelect(measModeCfg_r[MM_PERIOD_SEL_LSB +: 2]),
		.periodMode(lineCycleModeCfg_r[LCM_PERIOD_MODE]),
		.linePeriodMeas(linePeriodMeas)
	);

	// half-cycle counting over all selected phases
	always_comb begin
		halfCnt_nxt = halfCnt_r + {15'h0000, countOnes(zeroCross & crossEnable)};
		periodEnd = anyLine && (halfCycleCount_r != 16'h0000) &&
			(halfCnt_nxt >= {1'b0, halfCycleCount_r});
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			halfCnt_r <= 17'h00000;
		end else if (!anyLine || periodEnd) begin
			halfCnt_r <= 17'h00000;
		end else begin
			halfCnt_r <= halfCnt_nxt;
		end
	end

	// register writes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			measModeCfg_r <= MEAS_MODE_RST;
			lineCycleModeCfg_r <= LINE_CYC_MODE_RST;
			intEnable_r <= INT_ENABLE_RST;
			halfCycleCount_r <= HALF_CYCLES_RST;
			activePulseRateNum <= RATE_RST;
			activePulseRateDen <= RATE_RST;
			reactivePulseRateNum <= RATE_RST;
			reactivePulseRateDen <= RATE_RST;
		end else if (regWrEn) begin
			unique case (regAddr)
				ADDR_MEAS_MODE: measModeCfg_r <= regWrData[7:0];
				ADDR_LINE_CYC_MODE: lineCycleModeCfg_r <= regWrData[7:0];
				ADDR_INT_ENABLE: intEnable_r <= regWrData;
				ADDR_HALF_CYCLES: halfCycleCount_r <= regWrData[15:0];
				ADDR_ACT_NUM: activePulseRateNum <= regWrData[11:0];
				ADDR_ACT_DEN: activePulseRateDen <= regWrData[11:0];
				ADDR_REACT_NUM: reactivePulseRateNum <= regWrData[11:0];
				ADDR_REACT_DEN: reactivePulseRateDen <= regWrData[11:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 9; i++) begin
				gainTrim_r[i] <= GAIN_RST;
			end
		end else if (regWrEn && inRange(regAddr, ADDR_GAIN_FIRST, ADDR_GAIN_LAST)) begin
			gainTrim_r[4'(regAddr - ADDR_GAIN_FIRST)] <= regWrData[11:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int p = 0; p < 3; p++) begin
				phaseTrim_r[p] <= TRIM_RST;
			end
		end else if (regWrEn && inRange(regAddr, ADDR_TRIM_FIRST, ADDR_TRIM_LAST)) begin
			phaseTrim_r[2'(regAddr - ADDR_TRIM_FIRST)] <= regWrData[6:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phaseDelayCycles <= 39'h0000000000;
		end else begin
			for (int p = 0; p < 3; p++) begin
				phaseDelayCycles[p*13 +: 13] <= trimToCycles(phaseTrim_r[p]);
			end
		end
	end

	// clear on read only applies to free-running energies
	assign energyReadClear = regRdEn &&
		lineCycleModeCfg_r[LCM_CLEAR_ON_READ] &&
		inRange(regAddr, ADDR_WATT_A, ADDR_VA_C);

	// accumulate, publish at period end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 9; i++) begin
				acc_r[i] <= '0;
				pub_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 9; i++) begin
				logic signed [ENERGY_W-1:0] inc;
				logic signed [ENERGY_W-1:0] sum;
				inc = energyValid ? ENERGY_W'(scaledInc[i]) : '0;
				sum = acc_r[i] + inc;
				if (lineEnable[i/3] && periodEnd) begin
					pub_r[i] <= sum;
					acc_r[i] <= '0;
				end else if (!lineEnable[i/3] && energyReadClear &&
						regAddr == 7'(ADDR_WATT_A + 7'(i))) begin
					acc_r[i] <= inc;
				end else begin
					acc_r[i] <= sum;
				end
			end
		end
	end

	// status flags, set wins over the read clear
	assign flagsReadClear = regRdEn && (regAddr == ADDR_IRQ_FLAGS_CLR);

	always_comb begin
		irqFlags_nxt = flagsReadClear ? 24'h000000 : irqFlags_r;
		irqFlags_nxt[IRQ_ACCUM_DONE] = irqFlags_nxt[IRQ_ACCUM_DONE] | periodEnd;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irqFlags_r <= 24'h000000;
			irqN <= 1'b1;
			accumDoneEvent <= 1'b0;
		end else begin
			irqFlags_r <= irqFlags_nxt;
			irqN <= ~|(irqFlags_nxt & intEnable_r);
			accumDoneEvent <= periodEnd;
		end
	end

	// read mux
	always_comb begin
		rdMux = 24'h000000;
		if (inRange(regAddr, ADDR_WATT_A, ADDR_VA_C)) begin
			for (int i = 0; i < 9; i++) begin
				if (regAddr == 7'(ADDR_WATT_A + 7'(i))) begin
					rdMux = 24'(unsigned'(lineEnable[i/3] ? pub_r[i] : acc_r[i]));
				end
			end
		end else if (inRange(regAddr, ADDR_GAIN_FIRST, ADDR_GAIN_LAST)) begin
			rdMux = {12'h000, gainTrim_r[4'(regAddr - ADDR_GAIN_FIRST)]};
		end else if (inRange(regAddr, ADDR_TRIM_FIRST, ADDR_TRIM_LAST)) begin
			rdMux = {17'h00000, phaseTrim_r[2'(regAddr - ADDR_TRIM_FIRST)]};
		end else begin
			unique case (regAddr)
				ADDR_LINE_PERIOD: rdMux = {12'h000, linePeriodMeas};
				ADDR_MEAS_MODE: rdMux = {16'h0000, measModeCfg_r};
				ADDR_LINE_CYC_MODE: rdMux = {16'h0000, lineCycleModeCfg_r};
				ADDR_INT_ENABLE: rdMux = intEnable_r;
				ADDR_IRQ_FLAGS: rdMux = irqFlags_r;
				ADDR_IRQ_FLAGS_CLR: rdMux = irqFlags_r;
				ADDR_HALF_CYCLES: rdMux = {8'h00, halfCycleCount_r};
				ADDR_ACT_NUM: rdMux = {12'h000, activePulseRateNum};
				ADDR_ACT_DEN: rdMux = {12'h000, activePulseRateDen};
				ADDR_REACT_NUM: rdMux = {12'h000, reactivePulseRateNum};
				ADDR_REACT_DEN: rdMux = {12'h000, reactivePulseRateDen};
				default: rdMux = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 24'h000000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				regRdData <= rdMux;
			end
		end
	end

endmodule : line_cycle_energy_accum

/* File: lca_pkg.sv */
// constants for line-cycle energy accumulation and calibration registers
package lca_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 24;

	// register offsets
	localparam logic [6:0] ADDR_WATT_A = 7'h01;
	localparam logic [6:0] ADDR_VA_C = 7'h09;
	localparam logic [6:0] ADDR_LINE_PERIOD = 7'h10;
	localparam logic [6:0] ADDR_MEAS_MODE = 7'h14;
	localparam logic [6:0] ADDR_LINE_CYC_MODE = 7'h17;
	localparam logic [6:0] ADDR_INT_ENABLE = 7'h18;
	localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h19;
	localparam logic [6:0] ADDR_IRQ_FLAGS_CLR = 7'h1a;
	localparam logic [6:0] ADDR_HALF_CYCLES = 7'h1c;
	localparam logic [6:0] ADDR_GAIN_FIRST = 7'h2a;
	localparam logic [6:0] ADDR_GAIN_LAST = 7'h32;
	localparam logic [6:0] ADDR_TRIM_FIRST = 7'h3f;
	localparam logic [6:0] ADDR_TRIM_LAST = 7'h41;
	localparam logic [6:0] ADDR_ACT_NUM = 7'h45;
	localparam logic [6:0] ADDR_ACT_DEN = 7'h46;
	localparam logic [6:0] ADDR_REACT_NUM = 7'h47;
	localparam logic [6:0] ADDR_REACT_DEN = 7'h48;

	// line_cycle_mode_cfg fields
	localparam int LCM_ACCUM_LSB = 0;
	localparam int LCM_CROSS_LSB = 3;
	localparam int LCM_CLEAR_ON_READ = 6;
	localparam int LCM_PERIOD_MODE = 7;
	// measurement_mode_cfg field
	localparam int MM_PERIOD_SEL_LSB = 0;
	// interrupt flag position of the accumulation-done event
	localparam int IRQ_ACCUM_DONE = 12;

	// reset values
	localparam logic [7:0] MEAS_MODE_RST = 8'h00;
	localparam logic [7:0] LINE_CYC_MODE_RST = 8'h00;
	localparam logic [23:0] INT_ENABLE_RST = 24'h000000;
	localparam logic [15:0] HALF_CYCLES_RST = 16'hffff;
	localparam logic [11:0] GAIN_RST = 12'h000;
	localparam logic [6:0] TRIM_RST = 7'h00;
	localparam logic [11:0] RATE_RST = 12'h000;

	// gain scaling: value = inc * (1 + gain / 2^GAIN_FRAC)
	localparam int GAIN_FRAC = 12;

	// timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PERIOD_LSB_PS = 9600000;
	localparam int PERIOD_TICK_CYC = PERIOD_LSB_PS / CLK_PERIOD_PS;
	localparam int TRIM_POS_STEP_PS = 1200000;
	localparam int TRIM_NEG_STEP_PS = 2400000;
	localparam int TRIM_POS_CYC = TRIM_POS_STEP_PS / CLK_PERIOD_PS;
	localparam int TRIM_NEG_CYC = TRIM_NEG_STEP_PS / CLK_PERIOD_PS;
	// frequency value in 1/16 Hz: 16 / (period * 9.6 us)
	localparam logic [20:0] LINE_PERIOD_MEAS_NUMER = 21'(16 * (1000000000 / 9600));

	typedef enum logic [1:0] {
		DIV_IDLE = 2'b01,
		DIV_RUN = 2'b10
	} div_state_t;

endpackage : lca_pkg

/* File: energy_gain_scale.sv */
// scales one energy increment by one plus a signed 12-bit gain trim
module energy_gain_scale import lca_pkg::*; #(
	parameter int INC_W = 16
) (
	// increment in and out
	input wire logic signed [INC_W-1:0] incIn,
	input wire logic [11:0] gainTrim,
	output logic signed [INC_W-1:0] incOut
);

	logic signed [INC_W+11:0] product;
	logic signed [INC_W+11:0] shifted;

	always_comb begin
		product = incIn * $signed(gainTrim);
		shifted = product >>> GAIN_FRAC;
		incOut = incIn + shifted[INC_W-1:0];
	end

endmodule : energy_gain_scale

/* File: line_period_meter.sv */
// measures line period of one phase in 9.6 us units, or its frequency
module line_period_meter import lca_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// crossings and selection
	input wire logic [2:0] zeroCross,
	input wire logic [1:0] periodMeasureSelect,
	input wire logic periodMode,
	// result
	output logic [11:0] linePeriodMeas
);

	logic [8:0] tickCnt_r;
	logic tick;
	logic [11:0] tickTotal_r;
	logic [11:0] period_r;
	logic [11:0] line_period_meas_r;
	logic halfSeen_r;
	logic selCross;
	div_state_t divState_r;
	logic [4:0] bitIdx_r;
	logic [12:0] rem_r;
	logic [20:0] quo_r;
	logic [12:0] remShift;

	assign tick = (tickCnt_r == 9'(PERIOD_TICK_CYC - 1));
	assign selCross = (periodMeasureSelect != 2'h3) &&
		zeroCross[periodMeasureSelect];
	assign remShift = {rem_r[11:0], LINE_PERIOD_MEAS_NUMER[bitIdx_r]};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tickCnt_r <= 9'h000;
		end else begin
			// restart on capture so each reading is phase-locked to the crossing
			if (tick || (selCross && halfSeen_r)) begin
				tickCnt_r <= 9'h000;
			end else begin
				tickCnt_r <= tickCnt_r + 9'h001;
			end
		end
	end

	// one full cycle spans two crossings of the chosen phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			halfSeen_r <= 1'b0;
			tickTotal_r <= 12'h000;
			period_r <= 12'h000;
		end else if (selCross && halfSeen_r) begin
			halfSeen_r <= 1'b0;
			period_r <= tickTotal_r;
			tickTotal_r <= 12'h000;
		end else begin
			halfSeen_r <= halfSeen_r ^ selCross;
			if (tick && tickTotal_r != 12'hfff) begin
				tickTotal_r <= tickTotal_r + 12'h001;
			end
		end
	end

	// restoring divider for the frequency reading
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			divState_r <= DIV_IDLE;
			bitIdx_r <= 5'h00;
			rem_r <= 13'h0000;
			quo_r <= 21'h000000;
			line_period_meas_r <= 12'h000;
		end else begin
			unique case (divState_r)
				DIV_IDLE: begin
					if (period_r != 12'h000 && selCross && halfSeen_r) begin
						divState_r <= DIV_RUN;
					end
					bitIdx_r <= 5'd20;
					rem_r <= 13'h0000;
					quo_r <= 21'h000000;
				end
				DIV_RUN: begin
					if (remShift >= {1'b0, period_r}) begin
						rem_r <= remShift - {1'b0, period_r};
						quo_r <= {quo_r[19:0], 1'b1};
					end else begin
						rem_r <= remShift;
						quo_r <= {quo_r[19:0], 1'b0};
					end
					if (bitIdx_r == 5'h00) begin
						divState_r <= DIV_IDLE;
					end
					bitIdx_r <= bitIdx_r - 5'h01;
				end
			endcase
			if (divState_r == DIV_RUN && bitIdx_r == 5'h00) begin
				line_period_meas_r <= (|quo_r[19:11]) ? 12'hfff :
					{quo_r[10:0], remShift >= {1'b0, period_r}};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			linePeriodMeas <= 12'h000;
		end else begin
			linePeriodMeas <= periodMode ? period_r : line_period_meas_r;
		end
	end

endmodule : line_period_meter

/* File: lca_checker.sv */
// port-level assertions for the line-cycle energy accumulator
module lca_checker import lca_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic regRdValid,
	// line side and events
	input wire logic [2:0] zeroCross,
	input wire logic irqN,
	input wire logic accumDoneEvent,
	// calibration outputs
	input wire logic [38:0] phaseDelayCycles,
	input wire logic [11:0] activePulseRateNum
);
	logic [6:0] trimA_r;
	logic [11:0] actNum_r;
	logic [12:0] trimCyc;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// last phase A trim written by the host
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			trimA_r <= TRIM_RST;
		end else if (regWrEn && regAddr == ADDR_TRIM_FIRST) begin
			trimA_r <= regWrData[6:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			actNum_r <= RATE_RST;
		end else if (regWrEn && regAddr == ADDR_ACT_NUM) begin
			actNum_r <= regWrData[11:0];
		end
	end

	assign trimCyc = trimA_r[6] ? 13'(7'(-trimA_r)) * 13'd96 :
		13'(trimA_r) * 13'd48;

	read_answer_a: assert property (regRdEn |=> regRdValid)
		else $error("read strobe got no valid pulse");
	no_spurious_a: assert property (!regRdEn |=> !regRdValid)
		else $error("valid pulse without a read");
	data_hold_a: assert property (!regRdValid |-> $stable(regRdData))
		else $error("read data moved outside a read answer");
	done_pulse_a: assert property (accumDoneEvent |=> !accumDoneEvent)
		else $error("done event longer than one cycle");
	done_cross_a: assert property (accumDoneEvent |-> $past(zeroCross) != 3'h0)
		else $error("period ended without a crossing");
	irq_fall_a: assert property ($fell(irqN) |-> accumDoneEvent)
		else $error("interrupt raised without period end");
	irq_clear_a: assert property (
		(regRdEn && regAddr == ADDR_IRQ_FLAGS_CLR) ##1 !accumDoneEvent [*2]
		|-> irqN) else $error("interrupt still low after clearing read");
	trim_map_a: assert property (
		$changed(phaseDelayCycles[12:0]) |-> phaseDelayCycles[12:0] == trimCyc)
		else $error("phase A delay does not match trim");
	rate_copy_a: assert property (
		$changed(activePulseRateNum) |-> activePulseRateNum == actNum_r)
		else $error("active rate numerator not the written value");
endmodule : lca_checker

bind line_cycle_energy_accum lca_checker i_lca_checker (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWrEn(regWrEn),
	.regRdEn(regRdEn),
	.regRdData(regRdData),
	.regRdValid(regRdValid),
	.zeroCross(zeroCross),
	.irqN(irqN),
	.accumDoneEvent(accumDoneEvent),
	.phaseDelayCycles(phaseDelayCycles),
	.activePulseRateNum(activePulseRateNum)
);

/* File: lca_host.sv */
// host controller model driving the register port
module lca_host import lca_pkg::*; (
	// clock
	input wire logic sys_clk,
	// register port
	output logic [ADDR_W-1:0] regAddr,
	output logic [DATA_W-1:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic regRdValid
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		regAddr = '0;
		regWrData = '0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		// clear-on-read stays off while any line accumulation is on
		if (a == ADDR_LINE_CYC_MODE && d[2:0] != 3'h0) d[LCM_CLEAR_ON_READ] = 1'b0;
		@(posedge sys_clk);
		#2;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge sys_clk);
		#2;
		regWrEn = 1'b0;
		regWrData = ~d;
		regAddr = ~a;
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [23:0] d, output logic v);
		@(posedge sys_clk);
		#2;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge sys_clk);
		#2;
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
		v = regRdValid;
	endtask : rd
endmodule : lca_host

/* File: line_cycle_energy_accum_tb.sv */
// self-checking bench for the line-cycle energy accumulator
module line_cycle_energy_accum_tb import lca_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [6:0] regAddr;
	logic [23:0] regWrData, regRdData, rdVal;
	logic regWrEn, regRdEn, regRdValid, rdOk, irqN, accumDoneEvent;
	logic energyValid = 1'b0;
	logic [2:0] zeroCross = 3'h0;
	logic [47:0] wattInc = {16'd30, 16'd20, 16'd16};
	logic [47:0] reactiveInc = {16'hfffd, 16'd50, 16'd40};
	logic [47:0] apparentInc = {16'd90, 16'd80, 16'd70};
	logic [38:0] phaseDelayCycles;
	logic [11:0] actNum, actDen, reactNum, reactDen;
	int numErrors = 0;
	int numChecks = 0;
	int cycles = 0;

	always #12.5 sys_clk = ~sys_clk;

	line_cycle_energy_accum i_line_cycle_energy_accum (.sys_clk(sys_clk),
		.resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .energyValid(energyValid),
		.wattInc(wattInc), .reactiveInc(reactiveInc),
		.apparentInc(apparentInc), .zeroCross(zeroCross), .irqN(irqN),
		.accumDoneEvent(accumDoneEvent), .phaseDelayCycles(phaseDelayCycles),
		.activePulseRateNum(actNum), .activePulseRateDen(actDen),
		.reactivePulseRateNum(reactNum), .reactivePulseRateDen(reactDen));

	lca_host i_lca_host (.sys_clk(sys_clk), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .regRdValid(regRdValid));

	task automatic endSim();
		$display("checks %0d mismatches %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : endSim

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			endSim();
		end
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		numChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rdck(input logic [6:0] a, input logic [23:0] exp);
		i_lca_host.rd(a, rdVal, rdOk);
		check({39'h0, rdOk}, 40'h1);
		check({16'h0, rdVal}, {16'h0, exp});
	endtask : rdck

	// one cycle of increments together with crossing pulses
	task automatic step(input logic [2:0] z);
		@(posedge sys_clk);
		#2;
		energyValid = 1'b1;
		zeroCross = z;
		@(posedge sys_clk);
		#2;
		energyValid = 1'b0;
		zeroCross = 3'h0;
	endtask : step

	task automatic testReset();
		rdck(ADDR_LINE_CYC_MODE, 24'h0);
		rdck(ADDR_MEAS_MODE, 24'h0);
		rdck(ADDR_HALF_CYCLES, 24'h00ffff);
		rdck(7'h7f, 24'h0);
		$display("reset values done");
	endtask : testReset

	task automatic testAccum();
		logic [15:0] exp [9] = '{16'd16, 16'd40, 16'd60, 16'd80, 16'd100,
			16'hfffa, 16'd140, 16'd160, 16'd180};
		i_lca_host.wr(ADDR_GAIN_FIRST, 24'h000800);
		i_lca_host.wr(ADDR_LINE_CYC_MODE, 24'h00003f);
		i_lca_host.wr(ADDR_HALF_CYCLES, 24'h000004);
		i_lca_host.wr(ADDR_INT_ENABLE, 24'h001000);
		for (int p = 0; p < 2; p++) begin
			step(3'b011);
			check({39'h0, accumDoneEvent}, 40'h0);
			step(3'b011);
			check({38'h0, accumDoneEvent, irqN}, 40'h2);
			for (int i = 0; i < 9; i++) begin
				rdck(7'(ADDR_WATT_A + i), {8'h0, exp[i]});
			end
			rdck(ADDR_IRQ_FLAGS_CLR, 24'h001000);
			rdck(ADDR_IRQ_FLAGS, 24'h0);
			check({39'h0, irqN}, 40'h1);
		end
		$display("accumulation done");
	endtask : testAccum

	task automatic testSelect();
		i_lca_host.wr(ADDR_INT_ENABLE, 24'h0);
		i_lca_host.wr(ADDR_LINE_CYC_MODE, 24'h000009);
		i_lca_host.wr(ADDR_HALF_CYCLES, 24'h000002);
		step(3'b110);
		step(3'b110);
		step(3'b001);
		check({39'h0, accumDoneEvent}, 40'h0);
		step(3'b001);
		check({38'h0, accumDoneEvent, irqN}, 40'h3);
		rdck(ADDR_IRQ_FLAGS, 24'h001000);
		rdck(ADDR_WATT_A, 24'h000020);
		rdck(ADDR_IRQ_FLAGS_CLR, 24'h001000);
		$display("crossing select done");
	endtask : testSelect

	task automatic testPeriod();
		i_lca_host.wr(ADDR_LINE_CYC_MODE, 24'h000080);
		i_lca_host.wr(ADDR_MEAS_MODE, 24'h000002);
		// phase C crossings 1057 cycles apart, 2114 per period
		for (int k = 0; k < 6; k++) begin
			repeat (1055) @(posedge sys_clk);
			step(3'b100);
		end
		rdck(ADDR_LINE_PERIOD, 24'h000005);
		// frequency of so short a period saturates
		i_lca_host.wr(ADDR_LINE_CYC_MODE, 24'h000000);
		rdck(ADDR_LINE_PERIOD, 24'h000fff);
		$display("line period done");
	endtask : testPeriod

	task automatic testMap();
		i_lca_host.wr(ADDR_WATT_A, 24'h00abcd);
		rdck(ADDR_WATT_A, 24'h000030);
		for (logic [6:0] a = ADDR_GAIN_FIRST; a <= ADDR_GAIN_LAST; a++) begin
			i_lca_host.wr(a, 24'hfedc00 | 24'(a));
			rdck(a, 24'h000c00 | 24'(a));
		end
		for (logic [6:0] a = ADDR_ACT_NUM; a <= ADDR_REACT_DEN; a++) begin
			i_lca_host.wr(a, 24'hfedc00 | 24'(a));
			rdck(a, 24'h000c00 | 24'(a));
		end
		i_lca_host.wr(ADDR_TRIM_FIRST, 24'h000005);
		i_lca_host.wr(7'h40, 24'h00007e);
		i_lca_host.wr(ADDR_TRIM_LAST, 24'h000040);
		rdck(7'h40, 24'h00007e);
		rdck(ADDR_TRIM_LAST, 24'h000040);
		check({16'h0, actNum, actDen}, 40'hc45c46);
		check({16'h0, reactNum, reactDen}, 40'hc47c48);
		check({1'b0, phaseDelayCycles}, {1'b0, 13'h1800, 13'd192, 13'd240});
		$display("register map done");
	endtask : testMap

	initial begin
		repeat (3) @(posedge sys_clk);
		#2;
		resetn = 1'b1;
		testReset();
		testAccum();
		testSelect();
		testPeriod();
		testMap();
		endSim();
	end
endmodule : line_cycle_energy_accum_tb
